// ===== hdl/cisf_pkg.sv
// package: constants and decoding for the capture input select and filter
// Behaviour
// (RULE1) ch1 bits 1:0: 00 output, 01 input one, 10 input two, 11 trigger
// (RULE2) ch1 direction bits change only while channel 1 is disabled
// (RULE3) ch1 prescale bits 3:2 capture every 1, 2, 4 or 8 events
// (RULE4) ch1 filter code 0000 bypasses filter, sampling at the base clock
// (RULE5) filter codes 0001..1111 pick fixed divider and sample count pairs
// (RULE6) sample at clock/divider; pass a change after N agreeing samples
// (RULE7) ch2 direction bits 9:8 use the same source encoding as channel 1
// (RULE8) ch2 direction bits change only while channel 2 is disabled
// (RULE9) bits 11:10 hold ch2 prescale, read and write
// (RULE10) bits 15:12 hold ch2 filter, read and write
// (RULE11) ch2 prescale and filter codes mean the same as channel 1
// (RULE12) prescale counter restarts from zero while its channel is disabled
package cisf_pkg;

  // ************************************
  // register map
  // ************************************
  localparam logic [7:0]  CISF_CTRL_OFF   = 8'h00;
  localparam logic [7:0]  CISF_ENABLE_OFF = 8'h04;
  localparam logic [7:0]  CISF_STATUS_OFF = 8'h08;
  localparam logic [15:0] CISF_CTRL_RST   = 16'h0000;
  localparam logic [1:0]  CISF_ENABLE_RST = 2'h0;
  localparam logic [1:0]  CISF_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  CISF_RESP_SLVERR = 2'h2;

  // ************************************
  // field positions
  // ************************************
  localparam int CISF_DIR1_LSB = 0;
  localparam int CISF_PSC1_LSB = 2;
  localparam int CISF_FLT1_LSB = 4;
  localparam int CISF_DIR2_LSB = 8;
  localparam int CISF_PSC2_LSB = 10;
  localparam int CISF_FLT2_LSB = 12;
  localparam int CISF_CHAN_STRIDE = 8;

  // ************************************
  // direction codes
  // ************************************
  localparam logic [1:0] CISF_DIR_OUTPUT = 2'h0;
  localparam logic [1:0] CISF_DIR_IN_ONE = 2'h1;
  localparam logic [1:0] CISF_DIR_IN_TWO = 2'h2;
  localparam logic [1:0] CISF_DIR_TRIG   = 2'h3;

  // log2 of the sample divider for a filter code
  function automatic logic [2:0] cisf_div_log2(input logic [3:0] code);
    case (code)
      4'h0, 4'h1, 4'h2, 4'h3: cisf_div_log2 = 3'h0;
      4'h4, 4'h5:             cisf_div_log2 = 3'h1;
      4'h6, 4'h7:             cisf_div_log2 = 3'h2;
      4'h8, 4'h9:             cisf_div_log2 = 3'h3;
      4'hA, 4'hB, 4'hC:       cisf_div_log2 = 3'h4;
      default:                cisf_div_log2 = 3'h5;
    endcase
  endfunction

  // consecutive agreeing samples needed for a filter code
  function automatic logic [3:0] cisf_count(input logic [3:0] code);
    case (code)
      4'h1:                   cisf_count = 4'h2;
      4'h2:                   cisf_count = 4'h4;
      4'h4, 4'h6, 4'h8:       cisf_count = 4'h6;
      4'hB, 4'hE:             cisf_count = 4'h6;
      4'hA, 4'hD:             cisf_count = 4'h5;
      4'h0:                   cisf_count = 4'h1;
      default:                cisf_count = 4'h8;
    endcase
  endfunction

endpackage

// ===== hdl/cisf_filter.sv
// module: digital glitch filter for one capture input
`timescale 1ns/100ps
`default_nettype none
module cisf_filter
  import cisf_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // control and data
  input  wire logic [3:0] filter_code_in,
  input  wire logic       raw_in,
  output logic            level_out
);
  import cisf_pkg::*;

  logic [4:0] div_cnt_r;
  logic [3:0] agree_cnt_r;
  logic [4:0] div_mask;
  logic       tick;
  logic [3:0] need;

  // free running divider; low bits all ones mark a sample instant
  assign div_mask = 5'((6'h01 << cisf_div_log2(filter_code_in)) - 6'h01);
  assign tick     = (div_cnt_r & div_mask) == div_mask;
  assign need     = cisf_count(filter_code_in);

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      div_cnt_r <= 5'h00;
    else
      div_cnt_r <= div_cnt_r + 5'h01;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      level_out   <= 1'b0;
      agree_cnt_r <= 4'h0;
    end
    else if (filter_code_in == 4'h0)
    begin
      level_out   <= raw_in; // RULE4
      agree_cnt_r <= 4'h0;
    end
    else if (tick) // RULE6 RULE5
    begin
      if (raw_in == level_out)
        agree_cnt_r <= 4'h0;
      else if (agree_cnt_r + 4'h1 == need)
      begin
        level_out   <= raw_in; // RULE6
        agree_cnt_r <= 4'h0;
      end
      else
        agree_cnt_r <= agree_cnt_r + 4'h1;
    end
  end

  AST_FLT_BYPASS: assert property ( // RULE4
    @(posedge clk_sys_in) disable iff (rst_in)
    filter_code_in == 4'h0 |=> level_out == $past(raw_in))
    else $error("bypassed filter did not follow its input");

  AST_FLT_N_SAMPLES: assert property ( // RULE6
    @(posedge clk_sys_in) disable iff (rst_in)
    (filter_code_in != 4'h0 && $stable(filter_code_in)
      && level_out != $past(level_out))
      |-> $past(agree_cnt_r) == $past(need) - 4'h1 && $past(tick))
    else $error("filter changed level without N agreeing samples");

endmodule // cisf_filter
`default_nettype wire

// ===== hdl/cisf_prescale.sv
// module: capture event prescaler for one channel
`timescale 1ns/100ps
`default_nettype none
module cisf_prescale
  import cisf_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // control
  input  wire logic       enable_in,
  input  wire logic [1:0] prescale_in,
  // events
  input  wire logic       event_in,
  output logic            capture_out
);
  import cisf_pkg::*;

  logic [2:0] evt_cnt_r;
  logic [2:0] last;

  assign last = 3'((4'h1 << prescale_in) - 4'h1);

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || !enable_in)
    begin
      evt_cnt_r   <= 3'h0; // RULE12
      capture_out <= 1'b0;
    end
    else if (event_in)
    begin
      capture_out <= evt_cnt_r == last; // RULE3 RULE11
      evt_cnt_r   <= (evt_cnt_r == last) ? 3'h0 : evt_cnt_r + 3'h1;
    end
    else
      capture_out <= 1'b0;
  end

  AST_PSC_RESTART: assert property ( // RULE12
    @(posedge clk_sys_in) disable iff (rst_in)
    !enable_in |=> evt_cnt_r == 3'h0 && !capture_out)
    else $error("prescaler count survived a disabled channel");

  AST_PSC_EIGHT: assert property ( // RULE3
    @(posedge clk_sys_in) disable iff (rst_in)
    (capture_out && prescale_in == 2'h3 && $stable(prescale_in))
      |-> $past(evt_cnt_r) == 3'h7)
    else $error("divide by eight captured early");

  AST_PSC_ONE: assert property ( // RULE3
    @(posedge clk_sys_in) disable iff (rst_in)
    (enable_in && event_in && prescale_in == 2'h0) |=> capture_out)
    else $error("divide by one missed an event");

endmodule // cisf_prescale
`default_nettype wire

// ===== hdl/cisf_top.sv
// module: capture input select and filter with AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cisf_top
  import cisf_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // capture sources
  input  wire logic        timer_input_one_in,
  input  wire logic        timer_input_two_in,
  input  wire logic        internal_trigger_source_in,
  // capture outputs
  output logic             chan1_capture_input_out,
  output logic             chan2_capture_input_out,
  output logic             chan1_capture_out,
  output logic             chan2_capture_out
);
  import cisf_pkg::*;

  // ************************************
  // registers
  // ************************************
  logic [15:0] capture_mode_ctrl_1_r;
  logic [1:0]  channel_enable_reg_r;
  logic [15:0] ctrl_nxt;

  // ************************************
  // axi4-lite slave state
  // ************************************
  logic        aw_hold_r;
  logic [7:0]  aw_addr_r;
  logic        w_hold_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_do;

  assign wr_do = aw_hold_r && w_hold_r && !s_axi_bvalid_out;

  // source choice shared by both channels
  function automatic logic src_mux(input logic [1:0] dir,
                                   input logic       one,
                                   input logic       two,
                                   input logic       trg);
    case (dir)
      CISF_DIR_IN_ONE: src_mux = one;
      CISF_DIR_IN_TWO: src_mux = two;
      CISF_DIR_TRIG:   src_mux = trg;
      default:         src_mux = 1'b0;
    endcase
  endfunction

  // write address channel
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      aw_hold_r         <= 1'b0;
      aw_addr_r         <= 8'h00;
      s_axi_awready_out <= 1'b1;
    end
    else if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      aw_hold_r         <= 1'b1;
      aw_addr_r         <= s_axi_awaddr_in;
      s_axi_awready_out <= 1'b0;
    end
    else if (wr_do)
      aw_hold_r <= 1'b0;
    else if (s_axi_bvalid_out && s_axi_bready_in)
      s_axi_awready_out <= 1'b1;
  end

  // write data channel
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      w_hold_r         <= 1'b0;
      w_data_r         <= 32'h0000_0000;
      w_strb_r         <= 4'h0;
      s_axi_wready_out <= 1'b1;
    end
    else if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      w_hold_r         <= 1'b1;
      w_data_r         <= s_axi_wdata_in;
      w_strb_r         <= s_axi_wstrb_in;
      s_axi_wready_out <= 1'b0;
    end
    else if (wr_do)
      w_hold_r <= 1'b0;
    else if (s_axi_bvalid_out && s_axi_bready_in)
      s_axi_wready_out <= 1'b1;
  end

  // write response; unmapped and read-only words answer slverr
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= CISF_RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= (aw_addr_r == CISF_CTRL_OFF
                           || aw_addr_r == CISF_ENABLE_OFF)
                          ? CISF_RESP_OKAY : CISF_RESP_SLVERR;
    end
    else if (s_axi_bready_in)
      s_axi_bvalid_out <= 1'b0;
  end

  // ************************************
  // control register
  // ************************************
  always_comb
  begin
    ctrl_nxt = capture_mode_ctrl_1_r;
    if (w_strb_r[0])
      ctrl_nxt[7:0] = w_data_r[7:0];
    if (w_strb_r[1])
      ctrl_nxt[15:8] = w_data_r[15:8];
    // direction bits frozen while the channel runs
    if (channel_enable_reg_r[0])
      ctrl_nxt[CISF_DIR1_LSB +: 2] =
        capture_mode_ctrl_1_r[CISF_DIR1_LSB +: 2]; // RULE2
    if (channel_enable_reg_r[1])
      ctrl_nxt[CISF_DIR2_LSB +: 2] =
        capture_mode_ctrl_1_r[CISF_DIR2_LSB +: 2]; // RULE8
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      capture_mode_ctrl_1_r <= CISF_CTRL_RST;
    else if (wr_do && aw_addr_r == CISF_CTRL_OFF)
      capture_mode_ctrl_1_r <= ctrl_nxt; // RULE9 RULE10
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      channel_enable_reg_r <= CISF_ENABLE_RST;
    else if (wr_do && aw_addr_r == CISF_ENABLE_OFF && w_strb_r[0])
      channel_enable_reg_r <= w_data_r[1:0];
  end

  // ************************************
  // read channel
  // ************************************
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= CISF_RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rresp_out   <= CISF_RESP_OKAY;
      case (s_axi_araddr_in)
        CISF_CTRL_OFF:
          s_axi_rdata_out <= {16'h0000, capture_mode_ctrl_1_r};
        CISF_ENABLE_OFF:
          s_axi_rdata_out <= {30'h0000_0000, channel_enable_reg_r};
        CISF_STATUS_OFF:
          s_axi_rdata_out <= {30'h0000_0000, chan2_capture_input_out,
                              chan1_capture_input_out};
        default:
        begin
          s_axi_rdata_out <= 32'h0000_0000;
          s_axi_rresp_out <= CISF_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid_out && s_axi_rready_in)
    begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // ************************************
  // channels
  // ************************************
  logic [1:0] level;
  logic [1:0] capture;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      logic [1:0] dir;
      logic [1:0] prescale_factor;
      logic [3:0] flt;
      logic       src;
      logic       run;
      logic       level_prev_r;

      assign dir = capture_mode_ctrl_1_r[CISF_DIR1_LSB
                                         + ch*CISF_CHAN_STRIDE +: 2];
      assign prescale_factor = capture_mode_ctrl_1_r[CISF_PSC1_LSB
                                         + ch*CISF_CHAN_STRIDE +: 2];
      assign flt = capture_mode_ctrl_1_r[CISF_FLT1_LSB
                                         + ch*CISF_CHAN_STRIDE +: 4];
      // RULE1 RULE7: both channels share the source encoding
      assign src = src_mux(dir, timer_input_one_in, timer_input_two_in,
                           internal_trigger_source_in);
      // output direction keeps the capture path idle
      assign run = channel_enable_reg_r[ch] && dir != CISF_DIR_OUTPUT;

      cisf_filter u_filter (
        .clk_sys_in     (clk_sys_in),
        .rst_in         (rst_in),
        .filter_code_in (flt), // RULE11
        .raw_in         (src),
        .level_out      (level[ch])
      );

      always_ff @(posedge clk_sys_in)
      begin
        if (rst_in)
          level_prev_r <= 1'b0;
        else
          level_prev_r <= level[ch];
      end

      // rising filtered edge is the capture event
      cisf_prescale u_prescale (
        .clk_sys_in  (clk_sys_in),
        .rst_in      (rst_in),
        .enable_in   (run),
        .prescale_in (prescale_factor),
        .event_in    (level[ch] && !level_prev_r),
        .capture_out (capture[ch])
      );
    end
  endgenerate

  assign chan1_capture_input_out = level[0];
  assign chan2_capture_input_out = level[1];
  assign chan1_capture_out       = capture[0];
  assign chan2_capture_out       = capture[1];

  // ************************************
  // checks
  // ************************************
  AST_DIR1_LOCK: assert property ( // RULE2
    @(posedge clk_sys_in) disable iff (rst_in)
    channel_enable_reg_r[0] |=> capture_mode_ctrl_1_r[1:0]
      == $past(capture_mode_ctrl_1_r[1:0]))
    else $error("channel 1 direction changed while enabled");

  AST_DIR2_LOCK: assert property ( // RULE8
    @(posedge clk_sys_in) disable iff (rst_in)
    channel_enable_reg_r[1] |=> capture_mode_ctrl_1_r[9:8]
      == $past(capture_mode_ctrl_1_r[9:8]))
    else $error("channel 2 direction changed while enabled");

  AST_FIELD_WRITE: assert property ( // RULE10
    @(posedge clk_sys_in) disable iff (rst_in)
    (wr_do && aw_addr_r == CISF_CTRL_OFF && w_strb_r[1])
      |=> capture_mode_ctrl_1_r[15:10] == $past(w_data_r[15:10]))
    else $error("channel 2 prescale or filter write lost");

  AST_OUT_DIR_IDLE: assert property ( // RULE1
    @(posedge clk_sys_in) disable iff (rst_in)
    capture_mode_ctrl_1_r[1:0] == CISF_DIR_OUTPUT
      ##1 capture_mode_ctrl_1_r[1:0] == CISF_DIR_OUTPUT |-> !chan1_capture_out)
    else $error("output channel produced a capture");

  AST_RD_ANSWER: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (s_axi_arvalid_in && s_axi_arready_out)
      |=> s_axi_rvalid_out && !s_axi_arready_out)
    else $error("read answer not given one cycle after the address");

  // read data must stand until the master takes it
  AST_RD_HOLD: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (s_axi_rvalid_out && !s_axi_rready_in)
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read answer dropped before it was taken");

endmodule // cisf_top
`default_nettype wire

// ===== testbench/cisf_source_model.sv
// model of the timer input pins and trigger source feeding the block
`timescale 1ns/100ps
`default_nettype none
module cisf_source_model (
  // clock
  input  wire logic clk_sys_in,
  // source levels
  output var logic  timer_input_one_out,
  output var logic  timer_input_two_out,
  output var logic  internal_trigger_source_out
);
  initial
  begin
    timer_input_one_out = 1'b0;
    timer_input_two_out = 1'b0;
    internal_trigger_source_out = 1'b0;
  end

  // levels move just after an edge, like a synchronous source
  task automatic set_levels(input logic one, input logic two,
                            input logic trg);
    @(posedge clk_sys_in);
    timer_input_one_out <= one;
    timer_input_two_out <= two;
    internal_trigger_source_out <= trg;
  endtask

  // pulse train on input one; widths make it prompt or slow
  task automatic pulse_one(input int cnt, input int hi, input int lo);
    repeat (cnt)
    begin
      set_levels(1'b1, 1'b0, 1'b0);
      repeat (hi - 1) @(posedge clk_sys_in);
      set_levels(1'b0, 1'b0, 1'b0);
      repeat (lo - 1) @(posedge clk_sys_in);
    end
  endtask
endmodule // cisf_source_model
`default_nettype wire

// ===== testbench/cisf_top_tb_top.sv
// self-checking bench for the capture input select and filter block
`timescale 1ns/100ps
`default_nettype none
module cisf_top_tb_top;
  import cisf_pkg::*;
  // *****
  // signals
  // *****
  logic        clk_sys_in, rst_in;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0]  s_axi_wstrb_in;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
  logic        s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
  logic        s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out;
  logic        s_axi_rready_in;
  logic        timer_input_one_in, timer_input_two_in;
  logic        internal_trigger_source_in;
  logic        chan1_capture_input_out, chan2_capture_input_out;
  logic        chan1_capture_out, chan2_capture_out;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cap1_cnt = 0;
  int          cap2_cnt = 0;
  localparam logic [1:0] OK  = CISF_RESP_OKAY;
  localparam logic [1:0] ERR = CISF_RESP_SLVERR;
  // divider and agreeing sample count per filter code
  localparam int FDIV[16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16,
                              32, 32, 32};
  localparam int FCNT[16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5,
                              6, 8};

  cisf_top cisf_top_i (
    .clk_sys_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .timer_input_one_in,
    .timer_input_two_in, .internal_trigger_source_in, .chan1_capture_out,
    .chan1_capture_input_out, .chan2_capture_input_out, .chan2_capture_out
  );
  cisf_source_model cisf_source_model_i (
    .clk_sys_in,
    .timer_input_one_out(timer_input_one_in),
    .timer_input_two_out(timer_input_two_in),
    .internal_trigger_source_out(internal_trigger_source_in)
  );

  initial
  begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // capture pulses last one cycle, so count them at every edge
  always @(posedge clk_sys_in)
  begin
    if (chan1_capture_out === 1'b1) cap1_cnt <= cap1_cnt + 1;
    if (chan2_capture_out === 1'b1) cap2_cnt <= cap2_cnt + 1;
  end

  // *****
  // bus tasks
  // *****
  task automatic report_and_stop();
    $display("Checks: %0d mismatches: %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    @(posedge clk_sys_in);
    s_axi_awaddr_in <= a;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wdata_in <= d;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    forever
    begin
      @(posedge clk_sys_in);
      if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
      if (s_axi_bvalid_out === 1'b1) break;
    end
    check(32'(s_axi_bresp_out), 32'(er));
    s_axi_bready_in <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          input logic [1:0] er);
    @(posedge clk_sys_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    forever
    begin
      @(posedge clk_sys_in);
      if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
      if (s_axi_rvalid_out === 1'b1) break;
    end
    d = s_axi_rdata_out;
    check(32'(s_axi_rresp_out), 32'(er));
    s_axi_rready_in <= 1'b0;
  endtask

  // *****
  // scenarios
  // *****
  task automatic test_registers();
    logic [31:0] d;
    axi_read(CISF_CTRL_OFF, d, OK);
    check(d, 32'h0);
    axi_write(CISF_CTRL_OFF, 32'hFFFF, OK);
    axi_read(CISF_CTRL_OFF, d, OK);
    check(d, 32'hFFFF);
    axi_write(CISF_ENABLE_OFF, 32'h3, OK);
    axi_write(CISF_CTRL_OFF, 32'h0, OK);
    axi_read(CISF_CTRL_OFF, d, OK);
    check(d, 32'h0303);
    axi_write(CISF_ENABLE_OFF, 32'h1, OK);
    axi_write(CISF_CTRL_OFF, 32'h0, OK);
    axi_read(CISF_CTRL_OFF, d, OK);
    check(d, 32'h0003);
    axi_write(CISF_ENABLE_OFF, 32'h0, OK);
    axi_write(CISF_STATUS_OFF, 32'h3, ERR);
    axi_write(8'h10, 32'hFFFF, ERR);
    axi_read(8'h0C, d, ERR);
    axi_read(CISF_CTRL_OFF, d, OK);
    check(d, 32'h0003);
  endtask

  task automatic test_select();
    logic [2:0]  p;
    logic        e;
    logic [31:0] r;
    for (int s = 0; s < 4; s++)
    begin
      axi_write(CISF_CTRL_OFF, 32'(s) | (32'(s) << 8), OK);
      for (int k = 0; k < 8; k++)
      begin
        p = 3'(k);
        cisf_source_model_i.set_levels(p[0], p[1], p[2]);
        repeat (3) @(posedge clk_sys_in);
        e = (s == 0) ? 1'b0 : p[s - 1];
        check(32'(chan1_capture_input_out), 32'(e));
        check(32'(chan2_capture_input_out), 32'(e));
        axi_read(CISF_STATUS_OFF, r, OK);
        check(r, {30'h0, e, e});
      end
    end
    cisf_source_model_i.set_levels(1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge clk_sys_in);
  endtask

  // both channels watch input one with the same filter code
  task automatic test_filter();
    int   d, n, lo, hi, t1, t2;
    logic g;
    for (int c = 0; c < 16; c++)
    begin
      d = FDIV[c];
      n = FCNT[c];
      lo = (n - 1) * d + 2;
      hi = n * d + 3;
      axi_write(CISF_CTRL_OFF, (32'(c) << 12) | (32'(c) << 4) | 32'h0101, OK);
      g = 1'b0;
      if (n > 1) cisf_source_model_i.pulse_one(1, (n - 1) * d, 1);
      repeat (hi + d)
      begin
        @(posedge clk_sys_in);
        g |= chan1_capture_input_out | chan2_capture_input_out;
      end
      check(32'(g), 32'h0);
      cisf_source_model_i.set_levels(1'b1, 1'b0, 1'b0);
      t1 = 0;
      t2 = 0;
      for (int t = 1; t <= hi + 2; t++)
      begin
        @(posedge clk_sys_in);
        if (t1 == 0 && chan1_capture_input_out === 1'b1) t1 = t;
        if (t2 == 0 && chan2_capture_input_out === 1'b1) t2 = t;
      end
      check(32'(t1 >= lo && t1 <= hi), 32'h1);
      check(32'(t2 >= lo && t2 <= hi), 32'h1);
      cisf_source_model_i.set_levels(1'b0, 1'b0, 1'b0);
      repeat (hi + 2) @(posedge clk_sys_in);
      check(32'(chan1_capture_input_out), 32'h0);
    end
  endtask

  task automatic run_pulses(input int cnt, input int e1, input int e2);
    int b1, b2;
    b1 = cap1_cnt;
    b2 = cap2_cnt;
    cisf_source_model_i.pulse_one(cnt, 2, 3);
    repeat (6) @(posedge clk_sys_in);
    check(32'(cap1_cnt - b1), 32'(e1));
    check(32'(cap2_cnt - b2), 32'(e2));
  endtask

  task automatic test_prescale();
    for (int p = 0; p < 4; p++)
    begin
      axi_write(CISF_ENABLE_OFF, 32'h0, OK);
      axi_write(CISF_CTRL_OFF, (32'(p) << 10) | (32'(p) << 2) | 32'h0101, OK);
      axi_write(CISF_ENABLE_OFF, 32'h3, OK);
      run_pulses(16, 16 >> p, 16 >> p);
    end
    run_pulses(5, 0, 0);
    axi_write(CISF_ENABLE_OFF, 32'h0, OK);
    axi_write(CISF_ENABLE_OFF, 32'h3, OK);
    run_pulses(7, 0, 0);
    run_pulses(1, 1, 1);
    axi_write(CISF_ENABLE_OFF, 32'h0, OK);
    axi_write(CISF_CTRL_OFF, 32'h0, OK);
    axi_write(CISF_ENABLE_OFF, 32'h3, OK);
    run_pulses(4, 0, 0);
  endtask

  // *****
  // main sequence
  // *****
  initial
  begin
    rst_in = 1'b1;
    s_axi_awaddr_in = 8'h00;
    s_axi_araddr_in = 8'h00;
    s_axi_wdata_in = 32'h0;
    s_axi_wstrb_in = 4'hF;
    s_axi_awvalid_in = 1'b0;
    s_axi_wvalid_in = 1'b0;
    s_axi_bready_in = 1'b0;
    s_axi_arvalid_in = 1'b0;
    s_axi_rready_in = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    test_registers();
    test_select();
    test_filter();
    test_prescale();
    report_and_stop();
  end

  // whole run needs under ten thousand cycles
  initial
  begin
    repeat (30000) @(posedge clk_sys_in);
    mismatches++;
    report_and_stop();
  end
endmodule // cisf_top_tb_top
`default_nettype wire
